/* File: com_clock_ctrl.sv */
// smbus slave, configuration bytes and output mode control of the clock generator
`timescale 1ns/1ps

// How it works
// RL1: with the output enable pin low every output pair is high impedance.
// RL2: with enable high and the vendor test bit set, outputs enter an undefined test state.
// RL3: with enable high, skip pin low and test bit clear, all pairs carry the reference clock.
// RL4: with enable high, skip pin high and test bit clear, a pair carries the pll clock if selected.
// RL5: select bits 3 down to 0 govern output pairs 0 up to 3.
// RL6: after power up the test bit is 0 and all four select bits are 1.
// RL7: the device is only a bus slave taking byte and word reads and writes.
// RL8: no bus timeout and no packet error checking are implemented.
// RL9: byte 80h holds a reserved bit 7, multiplier select 6..4 at 001 and selects 3..0.
// RL10: byte 81h bit 2 picks the reference frequency and bit 0 is the test bit, both 0 at power up.
// RL11: the host keeps bit 3 of byte 81h at 1 and bits 1 and 0 at 0.
// RL12: reserved bits store and return what is written, have no effect and power up at 0; the code powers bit 3 of byte 81h up at 1.
// RL13: the third byte is read only with revision in the upper five bits and vendor code below.
// RL14: the multiplier select codes give 3, 4, 5, 6, 8, 9/2, 15/2 and 15/4.
// RL15: the slave address is 11011, then the two strap pins, then the read/write bit.
// RL16: the host sets the reference select to 0 for 100 MHz and 1 for 133 MHz.
// RL17: written selects and test bit act on the outputs without a power cycle.
module com_clock_ctrl
  import com_pkg::*;
#(
  parameter logic [REV_W-1:0]  DEV_REVISION = 5'h01,  // arbitrary value
  parameter logic [VEND_W-1:0] VENDOR_CODE  = 3'h5    // arbitrary value
)
(
  input  wire logic              core_clk,
  input  wire logic              srst,
  input  wire logic              ce,
  input  wire logic              linkClk,
  input  wire logic              sclIn,
  input  wire logic              sdaIn,
  output logic                   sdaOut,
  output logic                   sdaOe,
  input  wire logic              outEnable,
  input  wire logic              pllSkipN,
  input  wire logic              addrStrapLo,
  input  wire logic              addrStrapHi,
  output logic [3:0]             clockOutOe,
  output logic [3:0]             clockOutRefSel,
  output logic                   vendorTestActive,
  output logic [MULT_W-1:0]      pllMultSel,
  output logic [MNUM_W-1:0]      pllMultNum,
  output logic [MDEN_W-1:0]      pllMultDen,
  output logic                   refFreqSelect
);

  // link side: reset, enable and pin synchronisers
  logic [1:0]  lRstSync_q;
  logic [1:0]  lCeSync_q;
  logic [1:0]  sclSync_q;
  logic [1:0]  sdaSync_q;
  logic [1:0]  strapLoSync_q;
  logic [1:0]  strapHiSync_q;
  logic        sclPrev_q;
  logic        sdaPrev_q;

  // link side: protocol engine
  com_state_t  state_q;
  com_state_t  state_d;
  logic [3:0]  bitCnt_q;
  logic [3:0]  bitCnt_d;
  logic [7:0]  shift_q;
  logic [7:0]  shift_d;
  logic [7:0]  ptr_q;
  logic [7:0]  ptr_d;
  logic        rwRead_q;
  logic        rwRead_d;
  logic        sdaOe_q;
  logic        sdaOe_d;
  logic        mAck_q;
  logic        mAck_d;

  // link side: configuration bytes and change toggle
  logic [7:0]  regPll_q;
  logic [7:0]  regRef_q;
  logic        wrTgl_q;

  // core side
  logic [1:0]  tglSync_q;
  logic        tglPrev_q;
  logic [1:0]  enSync_q;
  logic [1:0]  skipSync_q;
  logic [7:0]  cfgPll_q;
  logic [7:0]  cfgRef_q;
  logic [MNUM_W-1:0] multNum_q;
  logic [MDEN_W-1:0] multDen_q;

  // decoding wires
  wire         lRst    = lRstSync_q[1];
  wire         lCe     = lCeSync_q[1];
  wire         sclS    = sclSync_q[1];
  wire         sdaS    = sdaSync_q[1];
  wire         sclRise = sclS & ~sclPrev_q;
  wire         sclFall = ~sclS & sclPrev_q;
  wire         startSeen = sclS & sclPrev_q & sdaPrev_q & ~sdaS;
  wire         stopSeen  = sclS & sclPrev_q & ~sdaPrev_q & sdaS;
  wire         rxState = (state_q == ST_ADDR) || (state_q == ST_CMD) ||
                         (state_q == ST_WDATA);
  wire         rxDone  = sclFall && (bitCnt_q == BYTE_BITS);
  wire [6:0]   ownAddr = {ADDR_FIXED, strapHiSync_q[1], strapLoSync_q[1]};
  wire         addrHit = (shift_q[7:1] == ownAddr);                      // [RL15]
  wire         regWrite = (state_q == ST_WDATA) && rxDone;
  wire         wrPll   = regWrite && (ptr_q == CMD_PLL_OUT);
  wire         wrRef   = regWrite && (ptr_q == CMD_REF_TEST);
  wire [7:0]   rdNow;
  wire [7:0]   ptrNext = 8'(ptr_q + 8'h01);
  wire         tglSeen = tglSync_q[1] ^ tglPrev_q;

  // read data; unknown commands read as zero
  function automatic logic [7:0] rdByte(input logic [7:0] cmd, input logic [7:0] pll,
                                        input logic [7:0] ref_b);
    unique case (cmd)
      CMD_PLL_OUT:  return pll;
      CMD_REF_TEST: return ref_b;
      CMD_REV_VEND: return {DEV_REVISION, VENDOR_CODE};                  // [RL13]
      default:      return RD_UNMAPPED;
    endcase
  endfunction : rdByte

  // multiplier ratio for the analog loop
  function automatic logic [MNUM_W+MDEN_W-1:0] multRatio(input logic [MULT_W-1:0] sel);
    unique case (sel)
      3'h0:    return {4'h3, 3'h1};
      3'h1:    return {4'h4, 3'h1};
      3'h2:    return {4'h5, 3'h1};
      3'h3:    return {4'h6, 3'h1};
      3'h4:    return {4'h8, 3'h1};
      3'h5:    return {4'h9, 3'h2};
      3'h6:    return {4'hf, 3'h2};
      default: return {4'hf, 3'h4};
    endcase
  endfunction : multRatio

  assign rdNow = rdByte(ptr_q, regPll_q, regRef_q);

  // reset and enable reach the link domain through two flops each
  always_ff @(posedge linkClk) begin
    lRstSync_q <= {lRstSync_q[0], srst};
    lCeSync_q  <= {lCeSync_q[0], ce};
  end

  // pins are sampled on the link clock, idle level is high
  always_ff @(posedge linkClk) begin
    if (lRst) begin
      sclSync_q <= 2'h3;
      sdaSync_q <= 2'h3;
      sclPrev_q <= 1'h1;
      sdaPrev_q <= 1'h1;
    end else if (lCe) begin
      sclSync_q <= {sclSync_q[0], sclIn};
      sdaSync_q <= {sdaSync_q[0], sdaIn};
      sclPrev_q <= sclS;
      sdaPrev_q <= sdaS;
    end
  end

  // straps may move at any time; the address follows them
  always_ff @(posedge linkClk) begin
    if (lRst) begin
      strapLoSync_q <= 2'h0;
      strapHiSync_q <= 2'h0;
    end else if (lCe) begin
      strapLoSync_q <= {strapLoSync_q[0], addrStrapLo};
      strapHiSync_q <= {strapHiSync_q[0], addrStrapHi};
    end
  end

  // slave only: sda is released or pulled low, scl is never driven; no
  // timeout and no packet error byte, a stuck master is freed by stop or start
  always_comb begin                                                      // [RL7] [RL8]
    state_d  = state_q;
    bitCnt_d = bitCnt_q;
    shift_d  = shift_q;
    ptr_d    = ptr_q;
    rwRead_d = rwRead_q;
    sdaOe_d  = sdaOe_q;
    mAck_d   = mAck_q;
    if (stopSeen) begin
      state_d = ST_IDLE;
      sdaOe_d = 1'b0;
    end else if (startSeen) begin
      state_d  = ST_ADDR;
      bitCnt_d = 4'h0;
      sdaOe_d  = 1'b0;
    end else begin
      if (rxState && sclRise) begin
        shift_d  = {shift_q[6:0], sdaS};
        bitCnt_d = 4'(bitCnt_q + 4'h1);
      end
      unique case (state_q)
        ST_IDLE: begin
        end
        ST_ADDR: begin
          if (rxDone) begin
            bitCnt_d = 4'h0;
            if (addrHit) begin
              sdaOe_d  = 1'b1;
              rwRead_d = shift_q[0];
              state_d  = ST_ACK_A;
            end else begin
              state_d = ST_IDLE;
            end
          end
        end
        ST_CMD: begin
          if (rxDone) begin
            bitCnt_d = 4'h0;
            ptr_d    = shift_q;
            sdaOe_d  = 1'b1;
            state_d  = ST_ACK_C;
          end
        end
        ST_WDATA: begin
          // word mode simply continues into the next byte
          if (rxDone) begin
            bitCnt_d = 4'h0;
            ptr_d    = ptrNext;
            sdaOe_d  = 1'b1;
            state_d  = ST_ACK_W;
          end
        end
        ST_ACK_A: begin
          if (sclFall) begin
            bitCnt_d = 4'h0;
            if (rwRead_q) begin
              shift_d = rdNow;
              ptr_d   = ptrNext;
              sdaOe_d = ~rdNow[BYTE_MSB];
              state_d = ST_RDATA;
            end else begin
              sdaOe_d = 1'b0;
              state_d = ST_CMD;
            end
          end
        end
        ST_ACK_C, ST_ACK_W: begin
          if (sclFall) begin
            sdaOe_d = 1'b0;
            state_d = ST_WDATA;
          end
        end
        ST_RDATA: begin
          if (sclFall) begin
            if (bitCnt_q == LAST_TX_BIT) begin
              bitCnt_d = 4'h0;
              sdaOe_d  = 1'b0;
              state_d  = ST_ACK_R;
            end else begin
              bitCnt_d = 4'(bitCnt_q + 4'h1);
              shift_d  = {shift_q[6:0], 1'b0};
              sdaOe_d  = ~shift_q[BYTE_MSB-1];
            end
          end
        end
        ST_ACK_R: begin
          if (sclRise)
            mAck_d = ~sdaS;
          if (sclFall) begin
            if (mAck_q) begin
              shift_d = rdNow;
              ptr_d   = ptrNext;
              sdaOe_d = ~rdNow[BYTE_MSB];
              state_d = ST_RDATA;
            end else begin
              state_d = ST_IDLE;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge linkClk) begin
    if (lRst) begin
      state_q  <= ST_IDLE;
      bitCnt_q <= 4'h0;
      shift_q  <= 8'h00;
      ptr_q    <= CMD_PLL_OUT;
      rwRead_q <= 1'b0;
      sdaOe_q  <= 1'b0;
      mAck_q   <= 1'b0;
    end else if (lCe) begin
      state_q  <= state_d;
      bitCnt_q <= bitCnt_d;
      shift_q  <= shift_d;
      ptr_q    <= ptr_d;
      rwRead_q <= rwRead_d;
      sdaOe_q  <= sdaOe_d;
      mAck_q   <= mAck_d;
    end
  end

  // whole bytes are stored, reserved bits included; writes to the
  // read-only or unmapped commands are acknowledged and dropped
  always_ff @(posedge linkClk) begin
    if (lRst) begin
      regPll_q <= PLL_OUT_POD;                                           // [RL6] [RL9]
      regRef_q <= REF_TEST_POD;                                          // [RL10] [RL12]
      wrTgl_q  <= 1'b0;
    end else if (lCe) begin
      if (wrPll)
        regPll_q <= shift_q;
      if (wrRef)
        regRef_q <= shift_q;                                             // [RL11]
      if (wrPll || wrRef)
        wrTgl_q <= ~wrTgl_q;
    end
  end

  assign sdaOut = 1'b0;
  assign sdaOe  = sdaOe_q;

  // core side: the toggle says the link bytes are settled and may be copied;
  // bytes only change once per nine scl bits, far slower than the crossing
  always_ff @(posedge core_clk) begin
    if (srst) begin
      tglSync_q  <= 2'h0;
      tglPrev_q  <= 1'b0;
      enSync_q   <= 2'h0;
      skipSync_q <= 2'h3;
    end else if (ce) begin
      tglSync_q  <= {tglSync_q[0], wrTgl_q};
      tglPrev_q  <= tglSync_q[1];
      enSync_q   <= {enSync_q[0], outEnable};
      skipSync_q <= {skipSync_q[0], pllSkipN};
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      cfgPll_q <= PLL_OUT_POD;                                           // [RL6]
      cfgRef_q <= REF_TEST_POD;
    end else if (ce && tglSeen) begin
      cfgPll_q <= regPll_q;                                              // [RL17]
      cfgRef_q <= regRef_q;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst)
      {multNum_q, multDen_q} <= multRatio(PLL_OUT_POD[MULT_LSB +: MULT_W]);
    else if (ce)
      {multNum_q, multDen_q} <= multRatio(cfgPll_q[MULT_LSB +: MULT_W]); // [RL14]
  end

  com_cfg_if cfgBus ();

  assign cfgBus.outSel     = cfgPll_q[OUTSEL_LSB +: OUTSEL_W];
  assign cfgBus.vendorTest = cfgRef_q[VTEST_BIT];
  assign cfgBus.outEnable  = enSync_q[1];
  assign cfgBus.pllSkipN   = skipSync_q[1];

  com_out_mode u_outMode (
    .core_clk   (core_clk),
    .srst       (srst),
    .ce         (ce),
    .cfg        (cfgBus.dst),
    .pairOe     (clockOutOe),
    .pairRef    (clockOutRefSel),
    .testActive (vendorTestActive)
  );

  assign pllMultSel    = cfgPll_q[MULT_LSB +: MULT_W];
  assign pllMultNum    = multNum_q;
  assign pllMultDen    = multDen_q;
  assign refFreqSelect = cfgRef_q[REF_FREQ_SELECT_BIT];                           // [RL16]

endmodule : com_clock_ctrl

/* File: com_pkg.sv */
// shared constants and types for the clock output mode control block
package com_pkg;

  // command codes of the configuration bytes
  localparam logic [7:0] CMD_PLL_OUT  = 8'h80;
  localparam logic [7:0] CMD_REF_TEST = 8'h81;
  localparam logic [7:0] CMD_REV_VEND = 8'h82;
  localparam logic [7:0] RD_UNMAPPED  = 8'h00;

  // power-on values
  localparam logic [7:0] PLL_OUT_POD  = 8'h1f;
  localparam logic [7:0] REF_TEST_POD = 8'h08;

  // field layout of the pll and output select byte
  localparam int OUTSEL_LSB = 0;
  localparam int OUTSEL_W   = 4;
  localparam int MULT_LSB   = 4;
  localparam int MULT_W     = 3;
  // field layout of the reference and test byte
  localparam int REF_FREQ_SELECT_BIT = 2;
  localparam int VTEST_BIT  = 0;
  // field layout of the read-only byte
  localparam int REV_W      = 5;
  localparam int VEND_W     = 3;

  // fixed upper address bits, straps follow
  localparam logic [4:0] ADDR_FIXED = 5'h1b;

  localparam int NUM_PAIRS = 4;
  localparam logic [3:0] BYTE_BITS   = 4'h8;
  localparam logic [3:0] LAST_TX_BIT = 4'h7;
  localparam int BYTE_MSB = 7;

  // multiplier ratio, numerator over denominator
  localparam int MNUM_W = 4;
  localparam int MDEN_W = 3;

  typedef enum logic [3:0] {
    MODE_HIZ  = 4'h1,
    MODE_PLL  = 4'h2,
    MODE_REF  = 4'h4,
    MODE_TEST = 4'h8
  } com_mode_t;

  typedef enum logic [8:0] {
    ST_IDLE  = 9'h001,
    ST_ADDR  = 9'h002,
    ST_ACK_A = 9'h004,
    ST_CMD   = 9'h008,
    ST_ACK_C = 9'h010,
    ST_WDATA = 9'h020,
    ST_ACK_W = 9'h040,
    ST_RDATA = 9'h080,
    ST_ACK_R = 9'h100
  } com_state_t;

endpackage : com_pkg

/* File: com_cfg_if.sv */
// settings that steer the output pair decoder
`timescale 1ns/1ps
interface com_cfg_if;
  logic [3:0] outSel;
  logic       vendorTest;
  logic       outEnable;
  logic       pllSkipN;

  modport src (output outSel, output vendorTest, output outEnable, output pllSkipN);
  modport dst (input outSel, input vendorTest, input outEnable, input pllSkipN);
endinterface : com_cfg_if

/* File: com_out_mode.sv */
// per pair output state decoder, registered
`timescale 1ns/1ps
module com_out_mode
  import com_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       srst,
  input  wire logic       ce,
  com_cfg_if.dst          cfg,
  output logic [3:0]      pairOe,
  output logic [3:0]      pairRef,
  output logic            testActive
);

  com_mode_t mode_d [NUM_PAIRS];
  com_mode_t mode_q [NUM_PAIRS];

  // select bit 3 steers pair 0, bit 0 steers pair 3
  function automatic com_mode_t pairMode(input logic en, input logic vt,
                                         input logic skipN, input logic sel);
    if (!en)
      return MODE_HIZ;                              // [RL1]
    else if (vt)
      return MODE_TEST;                             // [RL2]
    else if (!skipN)
      return MODE_REF;                              // [RL3]
    else
      return sel ? MODE_PLL : MODE_HIZ;             // [RL4]
  endfunction : pairMode

  for (genvar i = 0; i < NUM_PAIRS; i++) begin : g_pair
    assign mode_d[i] = pairMode(cfg.outEnable, cfg.vendorTest, cfg.pllSkipN,
                                cfg.outSel[NUM_PAIRS-1-i]);   // [RL5]
    always_ff @(posedge core_clk) begin
      if (srst)
        mode_q[i] <= MODE_HIZ;
      else if (ce)
        mode_q[i] <= mode_d[i];
    end
    // test state left undriven: its behaviour is not defined here
    assign pairOe[i]  = (mode_q[i] == MODE_PLL) || (mode_q[i] == MODE_REF);
    assign pairRef[i] = (mode_q[i] == MODE_REF);
  end

  assign testActive = (mode_q[0] == MODE_TEST);

endmodule : com_out_mode

/* File: com_clock_ctrl_checker.sv */
// concurrent checks on the ports of the clock output mode control block
`timescale 1ns/1ps
module com_clock_ctrl_checker
  import com_pkg::*;
(
  input wire logic              core_clk,
  input wire logic              srst,
  input wire logic              ce,
  input wire logic              linkClk,
  input wire logic              sclIn,
  input wire logic              sdaIn,
  input wire logic              sdaOut,
  input wire logic              sdaOe,
  input wire logic              outEnable,
  input wire logic              pllSkipN,
  input wire logic              addrStrapLo,
  input wire logic              addrStrapHi,
  input wire logic [3:0]        clockOutOe,
  input wire logic [3:0]        clockOutRefSel,
  input wire logic              vendorTestActive,
  input wire logic [MULT_W-1:0] pllMultSel,
  input wire logic [MNUM_W-1:0] pllMultNum,
  input wire logic [MDEN_W-1:0] pllMultDen,
  input wire logic              refFreqSelect
);
  logic [6:0] expRatio;

  always_comb begin
    case (pllMultSel)
      3'h0:    expRatio = {4'h3, 3'h1};
      3'h1:    expRatio = {4'h4, 3'h1};
      3'h2:    expRatio = {4'h5, 3'h1};
      3'h3:    expRatio = {4'h6, 3'h1};
      3'h4:    expRatio = {4'h8, 3'h1};
      3'h5:    expRatio = {4'h9, 3'h2};
      3'h6:    expRatio = {4'hf, 3'h2};
      default: expRatio = {4'hf, 3'h4};
    endcase
  end

  default clocking cb @(posedge core_clk);
  endclocking
  // a low enable freezes the pipeline, so no timing claim holds across it
  default disable iff (srst || !ce);

  // pin pipeline is three flops deep, so four quiet cycles settle it
  en_off_a: assert property ((!outEnable) [*4] |=> clockOutOe == 4'h0)
    else $error("pairs driven with enable low");
  bypass_ref_a: assert property ((outEnable && !pllSkipN && !vendorTestActive) [*4]
    |=> vendorTestActive || (clockOutOe == 4'hf && clockOutRefSel == 4'hf))
    else $error("bypass not on all pairs");
  pll_noref_a: assert property ((outEnable && pllSkipN && !vendorTestActive) [*4]
    |=> clockOutRefSel == 4'h0) else $error("reference shown outside bypass");
  test_undriven_a: assert property (vendorTestActive |-> clockOutOe == 4'h0)
    else $error("pairs driven in test state");
  ref_all_a: assert property (clockOutRefSel != 4'h0 |-> clockOutRefSel == 4'hf
    && clockOutOe == 4'hf) else $error("partial bypass");
  reset_fields_a: assert property ($fell(srst) |-> pllMultSel == 3'h1 && !refFreqSelect
    && {pllMultNum, pllMultDen} == {4'h4, 3'h1}) else $error("bad power-on fields");
  mult_ratio_a: assert property ($stable(pllMultSel) |-> {pllMultNum, pllMultDen} == expRatio)
    else $error("ratio does not match select");
  sda_pull_a: assert property (@(posedge linkClk) sdaOe |-> sdaOut == 1'b0)
    else $error("data pin driven high");
  sda_edge_a: assert property (@(posedge linkClk) $rose(sdaOe) |-> !sclIn)
    else $error("data pulled while bus clock high");

  cover property (clockOutRefSel == 4'hf);
  cover property (vendorTestActive);
  cover property (@(posedge linkClk) $rose(sdaOe));
endmodule : com_clock_ctrl_checker

bind com_clock_ctrl com_clock_ctrl_checker u_chk (
  .core_clk(core_clk), .srst(srst), .ce(ce), .linkClk(linkClk), .sclIn(sclIn),
  .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe), .outEnable(outEnable),
  .pllSkipN(pllSkipN), .addrStrapLo(addrStrapLo), .addrStrapHi(addrStrapHi),
  .clockOutOe(clockOutOe), .clockOutRefSel(clockOutRefSel),
  .vendorTestActive(vendorTestActive), .pllMultSel(pllMultSel), .pllMultNum(pllMultNum),
  .pllMultDen(pllMultDen), .refFreqSelect(refFreqSelect)
);

/* File: com_smb_host.sv */
// bus host model that configures the clock block over its two-wire bus
`timescale 1ns/1ps
module com_smb_host (
  input  wire logic sdaLine,
  output logic      sclLine,
  output logic      sdaPull
);
  // quarter bit, far above four link periods per clock phase
  localparam time QTR = 400ns;

  initial begin
    sclLine = 1'b1;
    sdaPull = 1'b0;
  end

  task automatic bit_io(input logic b, output logic r);
    #QTR sdaPull = !b;
    #QTR sclLine = 1'b1;
    #QTR r = sdaLine;
    #QTR sclLine = 1'b0;
  endtask : bit_io

  // also serves as repeated start
  task automatic start_c;
    #QTR sdaPull = 1'b0;
    #QTR sclLine = 1'b1;
    #QTR sdaPull = 1'b1;
    #QTR sclLine = 1'b0;
  endtask : start_c

  task automatic stop_c;
    #QTR sdaPull = 1'b1;
    #QTR sclLine = 1'b1;
    #QTR sdaPull = 1'b0;
    #QTR;
  endtask : stop_c

  task automatic byte_io(input logic [7:0] d, input logic nak, output logic [7:0] q,
                         output logic acked);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
      q[i] = r;
    end
    bit_io(nak, r);
    acked = !r;
  endtask : byte_io

  // byte or word write, no error-check byte follows
  task automatic wr_tx(input logic [7:0] adr, cmd, d0, d1, input int n, output logic ok);
    logic [7:0] q;
    logic       a0, a1, a2, a3;
    start_c();
    byte_io(adr, 1'b1, q, a0);
    byte_io(cmd, 1'b1, q, a1);
    byte_io(d0, 1'b1, q, a2);
    a3 = 1'b1;
    if (n == 2) byte_io(d1, 1'b1, q, a3);
    stop_c();
    ok = a0 & a1 & a2 & a3;
  endtask : wr_tx

  task automatic rd_tx(input logic [7:0] adr, cmd, input int n, output logic [7:0] q0, q1,
                       output logic ok);
    logic [7:0] q;
    logic       a0, a1, a2, ax;
    start_c();
    byte_io(adr, 1'b1, q, a0);
    byte_io(cmd, 1'b1, q, a1);
    start_c();
    byte_io(adr | 8'h01, 1'b1, q, a2);
    byte_io(8'hff, n == 1, q0, ax);
    q1 = 8'h00;
    if (n == 2) byte_io(8'hff, 1'b1, q1, ax);
    stop_c();
    ok = a0 & a1 & a2;
  endtask : rd_tx
endmodule : com_smb_host

/* File: tb.sv */
// self-checking bench for the clock output mode control block
`timescale 1ns/1ps
module tb;
  import com_pkg::*;
  localparam logic [4:0] REV  = 5'h0a;  // arbitrary value
  localparam logic [2:0] VEND = 3'h3;   // arbitrary value
  typedef struct packed {
    logic       en;
    logic       skipN;
    logic [7:0] cfg;
    logic [3:0] expOe;
    logic [3:0] expRef;
  } com_row_t;

  logic                core_clk, srst, ce, linkClk, outEnable, pllSkipN;
  logic                addrStrapLo, addrStrapHi, sclLine, sdaPull, sdaOut, sdaOe;
  logic                sdaLine, vendorTestActive, refFreqSelect, ok;
  logic [3:0]          clockOutOe, clockOutRefSel;
  logic [MULT_W-1:0]   pllMultSel;
  logic [MNUM_W-1:0]   pllMultNum;
  logic [MDEN_W-1:0]   pllMultDen;
  logic [7:0]          q0, q1;
  int                  n_errors = 0;
  int                  checked = 0;
  int                  cycles = 0;
  com_row_t            rows [8];

  // open drain data line with pull-up
  assign sdaLine = !(sdaPull || (sdaOe && !sdaOut));

  com_clock_ctrl #(.DEV_REVISION(REV), .VENDOR_CODE(VEND)) u_dut (
    .core_clk(core_clk), .srst(srst), .ce(ce), .linkClk(linkClk), .sclIn(sclLine),
    .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe), .outEnable(outEnable),
    .pllSkipN(pllSkipN), .addrStrapLo(addrStrapLo), .addrStrapHi(addrStrapHi),
    .clockOutOe(clockOutOe), .clockOutRefSel(clockOutRefSel),
    .vendorTestActive(vendorTestActive), .pllMultSel(pllMultSel),
    .pllMultNum(pllMultNum), .pllMultDen(pllMultDen), .refFreqSelect(refFreqSelect)
  );
  com_smb_host u_host (.sdaLine(sdaLine), .sclLine(sclLine), .sdaPull(sdaPull));

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  initial begin
    linkClk = 1'b0;
    #7;
    forever #24 linkClk = ~linkClk;
  end

  task automatic wrap_up;
    $display("checked %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : wrap_up

  // bus traffic takes about 1160 to 1920 cycles a transfer, 19 transfers
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      n_errors++;
      wrap_up();
    end
  end

  task automatic check_val(input logic [7:0] got, exp, input string what);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check_val

  task automatic check_flag(input logic got, exp, input string what);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check_flag

  task automatic do_reset;
    srst = 1'b1;
    repeat (10) @(negedge core_clk);
    srst = 1'b0;
    repeat (10) @(negedge core_clk);
  endtask : do_reset

  initial begin
    srst = 1'b1;
    ce = 1'b1;
    outEnable = 1'b1;
    pllSkipN = 1'b1;
    addrStrapLo = 1'b0;
    addrStrapHi = 1'b0;
    rows = '{{1'b0, 1'b1, 8'h0f, 4'h0, 4'h0}, {1'b1, 1'b0, 8'h10, 4'hf, 4'hf},
             {1'b1, 1'b1, 8'h28, 4'h1, 4'h0}, {1'b1, 1'b1, 8'h31, 4'h8, 4'h0},
             {1'b1, 1'b1, 8'h45, 4'ha, 4'h0}, {1'b1, 1'b1, 8'h5a, 4'h5, 4'h0},
             {1'b1, 1'b1, 8'h60, 4'h0, 4'h0}, {1'b1, 1'b1, 8'hff, 4'hf, 4'h0}};
    do_reset();
    for (int i = 0; i < 8; i++) begin
      @(negedge core_clk);
      outEnable = rows[i].en;
      pllSkipN = rows[i].skipN;
      u_host.wr_tx(8'hd8, CMD_PLL_OUT, rows[i].cfg, 8'h00, 1, ok);
      repeat (8) @(negedge core_clk);
      check_flag(ok, 1'b1, "write ack");
      check_val({4'h0, clockOutOe}, {4'h0, rows[i].expOe}, "oe");
      check_val({4'h0, clockOutRefSel}, {4'h0, rows[i].expRef}, "ref");
      check_val({5'h0, pllMultSel}, {5'h0, rows[i].cfg[6:4]}, "mult");
      $display("row %0d done", i);
    end
    do_reset();
    u_host.rd_tx(8'hd8, CMD_PLL_OUT, 2, q0, q1, ok);
    check_val(q0, 8'h1f, "byte 80");
    check_val(q1, 8'h08, "byte 81");
    check_val({4'h0, clockOutOe}, 8'h0f, "oe");
    $display("power-on test done");
    // host keeps bit 3 set and bits 1..0 clear, picks the faster reference
    u_host.wr_tx(8'hd8, CMD_PLL_OUT, 8'ha5, 8'h0c, 2, ok);
    u_host.rd_tx(8'hd8, CMD_PLL_OUT, 2, q0, q1, ok);
    check_flag(ok, 1'b1, "read ack");
    check_val(q0, 8'ha5, "byte 80");
    check_val(q1, 8'h0c, "byte 81");
    check_flag(refFreqSelect, 1'b1, "ref_freq_select");
    check_val({4'h0, clockOutOe}, 8'h0a, "oe");
    $display("word test done");
    u_host.wr_tx(8'hd8, CMD_REV_VEND, 8'h00, 8'h00, 1, ok);
    u_host.rd_tx(8'hd8, CMD_REV_VEND, 1, q0, q1, ok);
    check_val(q0, {REV, VEND}, "byte 82");
    u_host.rd_tx(8'hd8, 8'h90, 1, q0, q1, ok);
    check_val(q0, 8'h00, "unmapped");
    $display("read-only test done");
    // test bit on purpose, then back to normal
    u_host.wr_tx(8'hd8, CMD_REF_TEST, 8'h0d, 8'h00, 1, ok);
    repeat (8) @(negedge core_clk);
    check_flag(vendorTestActive, 1'b1, "test");
    check_val({4'h0, clockOutOe}, 8'h00, "oe");
    u_host.wr_tx(8'hd8, CMD_REF_TEST, 8'h0c, 8'h00, 1, ok);
    repeat (8) @(negedge core_clk);
    check_val({4'h0, clockOutOe}, 8'h0a, "oe");
    $display("test-bit test done");
    // enable low freezes the pin pipeline, so the old state must stay
    ce = 1'b0;
    outEnable = 1'b0;
    repeat (8) @(negedge core_clk);
    check_val({4'h0, clockOutOe}, 8'h0a, "frozen");
    ce = 1'b1;
    repeat (8) @(negedge core_clk);
    check_val({4'h0, clockOutOe}, 8'h00, "oe");
    outEnable = 1'b1;
    $display("clock enable test done");
    addrStrapHi = 1'b1;
    repeat (10) @(negedge core_clk);
    u_host.wr_tx(8'hd8, CMD_PLL_OUT, 8'h1f, 8'h00, 1, ok);
    check_flag(ok, 1'b0, "old address");
    u_host.wr_tx(8'hdc, CMD_PLL_OUT, 8'h13, 8'h00, 1, ok);
    u_host.rd_tx(8'hdc, CMD_PLL_OUT, 1, q0, q1, ok);
    check_flag(ok, 1'b1, "new address");
    check_val(q0, 8'h13, "byte 80");
    $display("address test done");
    wrap_up();
  end
endmodule : tb
